// File: design/amf_top.sv
// Mode-control port and output-word formatter of a dual-channel 16-bit converter.
// Assumes pins arrive asynchronously; the sample stream is on i_sys_clk.
`timescale 1ns/10ps
module amf_top #(
   parameter int SMP_W = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Mode port pins
   input wire logic i_program_style_select,
   input wire logic i_cs_b,
   input wire logic i_sck,
   input wire logic i_sdi,
   input wire logic i_sdo,
   output logic o_sdo,
   output logic o_sdo_oe_b,
   // Sample stream in
   input wire logic i_smp_valid,
   input wire logic [SMP_W-1:0] i_ch1_sample_bits,
   input wire logic i_ch1_over_range_flag,
   input wire logic [SMP_W-1:0] i_ch2_sample_bits,
   input wire logic i_ch2_over_range_flag,
   output logic o_smp_ready,
   // Formatted output
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [SMP_W-1:0] o_ch1_sample_bits,
   output logic o_ch1_over_range_flag,
   output logic [SMP_W-1:0] o_ch2_sample_bits,
   output logic o_ch2_over_range_flag,
   output logic o_output_data_clock,
   output logic o_out_oe_b,
   // Mode controls
   output logic o_dcs_on,
   output logic [1:0] o_out_mode,
   output logic [2:0] o_lvds_current,
   output logic o_term_on,
   output logic [1:0] o_clk_phase,
   output logic o_clk_invert,
   output logic o_ch1_nap,
   output logic o_ch2_nap,
   output logic o_sleep
);
   localparam int WORD_W = 2 * SMP_W + 2;

   // Pin synchronisers
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   logic cs_b_d_r;
   logic sck_d_r;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         // Idle pin levels, so no false select edge or strap state after reset
         pin_s1_r <= 5'h09;
         pin_s2_r <= 5'h09;
         cs_b_d_r <= 1'b1;
         sck_d_r <= 1'b0;
      end else begin
         pin_s1_r <= {i_program_style_select, i_cs_b, i_sck, i_sdi, i_sdo};
         pin_s2_r <= pin_s1_r;
         cs_b_d_r <= pin_s2_r[3];
         sck_d_r <= pin_s2_r[2];
      end
   end

   logic strap_mode;
   logic cs_b_s;
   logic sck_s;
   logic sdi_s;
   logic sdo_s;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   assign strap_mode = pin_s2_r[4];
   assign cs_b_s = pin_s2_r[3];
   assign sck_s = pin_s2_r[2];
   assign sdi_s = pin_s2_r[1];
   assign sdo_s = pin_s2_r[0];
   assign cs_fall = cs_b_d_r & ~cs_b_s;
   assign cs_rise = ~cs_b_d_r & cs_b_s;
   assign sck_rise = ~sck_d_r & sck_s;
   assign sck_fall = sck_d_r & ~sck_s;

   // Serial engine
   amf_pkg::ser_state_type ser_state_r;
   logic [4:0] bit_cnt_r;
   logic [15:0] shift_r;
   logic [7:0] rd_shift_r;
   logic rd_active_r;
   logic [1:0] pd_reg_r;
   logic [3:0] tm_reg_r;
   logic [6:0] om_reg_r;
   logic [5:0] df_reg_r;
   logic sw_rst_sleep_r;
   logic [7:0] rd_data;
   logic wr_commit;
   logic sw_rst;

   always_comb begin
      case (shift_r[6:0])
         amf_pkg::ADDR_POWER_DOWN: rd_data = {6'h00, pd_reg_r};
         amf_pkg::ADDR_TIMING: rd_data = {4'h0, tm_reg_r};
         amf_pkg::ADDR_OUTPUT_MODE: rd_data = {1'b0, om_reg_r};
         amf_pkg::ADDR_DATA_FORMAT: rd_data = {2'h0, df_reg_r};
         default: rd_data = amf_pkg::REG_RESET_VAL;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ser_state_r <= amf_pkg::ST_IDLE;
         bit_cnt_r <= 5'h00;
         shift_r <= 16'h0000;
      end else if (strap_mode) begin
         ser_state_r <= amf_pkg::ST_IDLE;
         bit_cnt_r <= 5'h00;
      end else begin
         case (ser_state_r)
            amf_pkg::ST_IDLE: begin
               if (cs_fall) begin
                  ser_state_r <= amf_pkg::ST_SHIFT;
                  bit_cnt_r <= 5'h00;
               end
            end
            amf_pkg::ST_SHIFT: begin
               if (cs_rise) begin
                  ser_state_r <= amf_pkg::ST_IDLE;
               end else if (sck_rise) begin
                  shift_r <= {shift_r[14:0], sdi_s};
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (bit_cnt_r == 5'(amf_pkg::SER_WORD_BITS - 1)) begin
                     ser_state_r <= amf_pkg::ST_DONE;
                  end
               end
            end
            amf_pkg::ST_DONE: begin
               // Edges past the sixteenth are ignored
               if (cs_rise) begin
                  ser_state_r <= amf_pkg::ST_IDLE;
               end
            end
            default: ser_state_r <= amf_pkg::ST_IDLE;
         endcase
      end
   end

   // write lands when the frame closes
   assign wr_commit = (ser_state_r == amf_pkg::ST_DONE) && cs_rise && !shift_r[15] && !strap_mode;
   // reset bit acts but is never stored
   assign sw_rst = wr_commit && (shift_r[14:8] == amf_pkg::ADDR_RESET) && shift_r[amf_pkg::RESET_BIT];

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pd_reg_r <= 2'h0;
         tm_reg_r <= 4'h0;
         om_reg_r <= 7'h00;
         df_reg_r <= 6'h00;
      end else if (sw_rst) begin
         pd_reg_r <= 2'h0;
         tm_reg_r <= 4'h0;
         om_reg_r <= 7'h00;
         df_reg_r <= 6'h00;
      end else if (wr_commit) begin
         case (shift_r[14:8])
            amf_pkg::ADDR_POWER_DOWN: pd_reg_r <= shift_r[amf_pkg::PD_LSB +: 2];
            amf_pkg::ADDR_TIMING: tm_reg_r <= shift_r[3:0];
            amf_pkg::ADDR_OUTPUT_MODE: om_reg_r <= shift_r[6:0];
            amf_pkg::ADDR_DATA_FORMAT: df_reg_r <= shift_r[5:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sw_rst_sleep_r <= 1'b0;
      end else begin
         sw_rst_sleep_r <= sw_rst;
      end
   end

   // read shifter, MSB first after the header
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_active_r <= 1'b0;
         rd_shift_r <= 8'hFF;
      end else if (strap_mode || cs_b_s || ser_state_r == amf_pkg::ST_IDLE) begin
         rd_active_r <= 1'b0;
         rd_shift_r <= 8'hFF;
      end else if (sck_rise && bit_cnt_r == 5'(amf_pkg::SER_HDR_BITS - 1) && shift_r[6]) begin
         // Header completes on this edge: flag in shift_r[6], address from sdi
         rd_active_r <= 1'b1;
         rd_shift_r <= 8'hFF;
      end else if (rd_active_r && sck_fall && bit_cnt_r == 5'(amf_pkg::SER_HDR_BITS)) begin
         rd_shift_r <= rd_data;
      end else if (rd_active_r && sck_fall && bit_cnt_r > 5'(amf_pkg::SER_HDR_BITS)) begin
         rd_shift_r <= {rd_shift_r[6:0], 1'b1};
      end
   end

   // open drain: only ever pulls low
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sdo <= 1'b0;
         o_sdo_oe_b <= 1'b1;
      end else begin
         o_sdo <= 1'b0;
         o_sdo_oe_b <= !(rd_active_r && !rd_shift_r[7] && !strap_mode);
      end
   end

   // Effective modes from straps or registers
   logic [1:0] pd_code;
   always_comb begin
      pd_code = strap_mode ? {sdi_s, sdo_s} : pd_reg_r;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dcs_on <= 1'b0;
         o_out_mode <= amf_pkg::OUT_MODE_CMOS;
         o_lvds_current <= amf_pkg::ILVDS_3P5MA;
         o_term_on <= 1'b0;
         o_clk_phase <= 2'h0;
         o_clk_invert <= 1'b0;
      end else if (strap_mode) begin
         o_dcs_on <= cs_b_s;
         o_out_mode <= sck_s ? amf_pkg::OUT_MODE_LVDS : amf_pkg::OUT_MODE_CMOS;
         o_lvds_current <= amf_pkg::ILVDS_3P5MA;
         o_term_on <= 1'b0;
         o_clk_phase <= 2'h0;
         o_clk_invert <= 1'b0;
      end else begin
         o_dcs_on <= tm_reg_r[amf_pkg::TM_DCS];
         o_out_mode <= om_reg_r[amf_pkg::OM_MODE_LSB +: 2];
         o_lvds_current <= om_reg_r[amf_pkg::OM_ILVDS_LSB +: 3];
         o_term_on <= om_reg_r[amf_pkg::OM_TERM];
         o_clk_phase <= tm_reg_r[amf_pkg::TM_PHASE_LSB +: 2];
         o_clk_invert <= tm_reg_r[amf_pkg::TM_INV];
      end
   end

   // channel 1 naps only together with channel 2
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_ch1_nap <= 1'b0;
         o_ch2_nap <= 1'b0;
         o_sleep <= 1'b0;
      end else begin
         o_ch1_nap <= (pd_code == amf_pkg::PD_BOTH_NAP);
         o_ch2_nap <= (pd_code == amf_pkg::PD_CH2_NAP) || (pd_code == amf_pkg::PD_BOTH_NAP);
         o_sleep <= (pd_code == amf_pkg::PD_SLEEP) || sw_rst || sw_rst_sleep_r;
      end
   end

   // Output formatting
   logic twos_en;
   logic rand_en;
   logic abp_en;
   logic [2:0] tp_sel;
   logic tp_phase_r;
   logic push;
   logic pop;
   assign twos_en = !strap_mode && df_reg_r[amf_pkg::DF_TWOS];
   assign rand_en = !strap_mode && df_reg_r[amf_pkg::DF_RAND];
   assign abp_en = !strap_mode && df_reg_r[amf_pkg::DF_ABP];
   assign tp_sel = strap_mode ? amf_pkg::TP_OFF : df_reg_r[amf_pkg::DF_TP_LSB +: 3];

   function automatic logic [SMP_W:0] fmt_word(input logic [SMP_W-1:0] bits, input logic ovr,
                                                input logic [2:0] tp, input logic ph,
                                                input logic twos, input logic rnd, input logic abp);
      logic [SMP_W-1:0] w;
      w = bits;
      case (tp)
         amf_pkg::TP_ONES: fmt_word = {1'b1, {SMP_W{1'b1}}};
         amf_pkg::TP_ZEROS: fmt_word = {1'b0, {SMP_W{1'b0}}};
         amf_pkg::TP_ALTERNATE: fmt_word = {ph, {SMP_W{ph}}};
         amf_pkg::TP_CHECKER: begin
            w = ph ? ~amf_pkg::CHECKER_WORD[SMP_W-1:0] : amf_pkg::CHECKER_WORD[SMP_W-1:0];
            fmt_word = {ph, w};
         end
         default: begin
            if (twos) begin
               w[SMP_W-1] = ~w[SMP_W-1];
            end
            // randomizer stands on its own enable
            if (rnd) begin
               w[SMP_W-1:1] = w[SMP_W-1:1] ^ {(SMP_W - 1){w[0]}};
            end
            if (abp) begin
               w = w ^ amf_pkg::ODD_BIT_MASK[SMP_W-1:0];
            end
            fmt_word = {ovr, w};
         end
      endcase
   endfunction

   logic [WORD_W-1:0] in_word;
   assign in_word = {fmt_word(i_ch2_sample_bits, i_ch2_over_range_flag, tp_sel, tp_phase_r,
                              twos_en, rand_en, abp_en),
                     fmt_word(i_ch1_sample_bits, i_ch1_over_range_flag, tp_sel, tp_phase_r,
                              twos_en, rand_en, abp_en)};
   assign push = i_smp_valid && o_smp_ready;
   assign pop = o_out_valid && i_out_ready;

   // pattern phase steps once per sample
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tp_phase_r <= 1'b1;
      end else if (tp_sel == amf_pkg::TP_OFF) begin
         tp_phase_r <= 1'b1;
      end else if (push) begin
         tp_phase_r <= ~tp_phase_r;
      end
   end

   // Two-entry buffer: head drives the pins, spare absorbs a stall
   logic [WORD_W-1:0] head_r;
   logic [WORD_W-1:0] spare_r;
   logic spare_v_r;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         head_r <= '0;
         spare_r <= '0;
         o_out_valid <= 1'b0;
         spare_v_r <= 1'b0;
         o_smp_ready <= 1'b0;
      end else begin
         if (!o_out_valid || pop) begin
            if (spare_v_r) begin
               head_r <= spare_r;
               o_out_valid <= 1'b1;
               spare_v_r <= push;
               spare_r <= in_word;
            end else begin
               head_r <= in_word;
               o_out_valid <= push;
            end
         end else if (push) begin
            spare_r <= in_word;
            spare_v_r <= 1'b1;
         end
         o_smp_ready <= !(spare_v_r ? !(pop) || push : (o_out_valid && !pop && push));
      end
   end

   // data clock marks each word, no polarity transform
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_output_data_clock <= 1'b0;
      end else if (pop) begin
         o_output_data_clock <= ~o_output_data_clock;
      end
   end

   assign o_ch1_sample_bits = head_r[SMP_W-1:0];
   assign o_ch1_over_range_flag = head_r[SMP_W];
   assign o_ch2_sample_bits = head_r[2*SMP_W:SMP_W+1];
   assign o_ch2_over_range_flag = head_r[WORD_W-1];

   // one enable floats data, flags and clock
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_out_oe_b <= 1'b0;
      end else begin
         o_out_oe_b <= !strap_mode && om_reg_r[amf_pkg::OM_OFF];
      end
   end
endmodule

// File: include/amf_pkg.sv
// Shared constants for the converter mode-control block.
// Assumes a single system clock; the mode port pins are asynchronous to it, the sample stream is on it.
package amf_pkg;
   // Serial word layout
   localparam int SER_WORD_BITS = 16;
   localparam int SER_HDR_BITS = 8;
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
   localparam logic [6:0] ADDR_TIMING = 7'h02;
   localparam logic [6:0] ADDR_OUTPUT_MODE = 7'h03;
   localparam logic [6:0] ADDR_DATA_FORMAT = 7'h04;
   localparam int RESET_BIT = 7;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   // Power-down register fields and codes
   localparam int PD_LSB = 0;
   localparam logic [1:0] PD_NORMAL = 2'h0;
   localparam logic [1:0] PD_CH2_NAP = 2'h1;
   localparam logic [1:0] PD_BOTH_NAP = 2'h2;
   localparam logic [1:0] PD_SLEEP = 2'h3;
   // Timing register fields
   localparam int TM_DCS = 0;
   localparam int TM_PHASE_LSB = 1;
   localparam int TM_INV = 3;
   // Output mode register fields
   localparam int OM_MODE_LSB = 0;
   localparam int OM_OFF = 2;
   localparam int OM_TERM = 3;
   localparam int OM_ILVDS_LSB = 4;
   localparam logic [1:0] OUT_MODE_CMOS = 2'h0;
   localparam logic [1:0] OUT_MODE_LVDS = 2'h1;
   localparam logic [2:0] ILVDS_3P5MA = 3'h0;
   // Data format register fields
   localparam int DF_TWOS = 0;
   localparam int DF_RAND = 1;
   localparam int DF_ABP = 2;
   localparam int DF_TP_LSB = 3;
   localparam logic [2:0] TP_OFF = 3'h0;
   localparam logic [2:0] TP_ONES = 3'h1;
   localparam logic [2:0] TP_ZEROS = 3'h2;
   localparam logic [2:0] TP_ALTERNATE = 3'h3;
   localparam logic [2:0] TP_CHECKER = 3'h4;
   localparam logic [15:0] CHECKER_WORD = 16'hAAAA;
   localparam logic [15:0] ODD_BIT_MASK = 16'hAAAA;
   // Serial engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } ser_state_type;
endpackage

// File: test/amf_props.sv
// Port assertions for the converter mode-control block.
// Assumes binding into amf_top; single clock domain.
`timescale 1ns/10ps
module amf_props #(
   parameter int SMP_W = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_program_style_select,
   input wire logic i_cs_b,
   input wire logic i_sck,
   input wire logic i_sdi,
   input wire logic i_sdo,
   input wire logic o_sdo,
   input wire logic o_sdo_oe_b,
   input wire logic i_smp_valid,
   input wire logic o_smp_ready,
   input wire logic o_out_valid,
   input wire logic i_out_ready,
   input wire logic [SMP_W-1:0] o_ch1_sample_bits,
   input wire logic [SMP_W-1:0] o_ch2_sample_bits,
   input wire logic o_output_data_clock,
   input wire logic o_dcs_on,
   input wire logic [1:0] o_out_mode,
   input wire logic [2:0] o_lvds_current,
   input wire logic o_term_on,
   input wire logic o_ch1_nap,
   input wire logic o_ch2_nap,
   input wire logic o_sleep
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // Straps held long enough to pass the synchronisers
   sequence strap_s;
      (i_program_style_select && $stable({i_cs_b, i_sck, i_sdi, i_sdo}))[*6];
   endsequence
   sequence take_s;
      o_out_valid && i_out_ready;
   endsequence
   sdo_open_drain_a: assert property (!o_sdo_oe_b |-> !o_sdo)
      else $error("data out driven high");
   sdo_release_a: assert property (i_cs_b [*6] |-> o_sdo_oe_b)
      else $error("data out held after frame");
   nap_pair_a: assert property (o_ch1_nap |-> o_ch2_nap)
      else $error("channel 1 naps alone");
   strap_dcs_a: assert property (strap_s |-> o_dcs_on == i_cs_b)
      else $error("stabilizer strap wrong");
   strap_fmt_a: assert property (strap_s |-> o_out_mode == (i_sck ? 2'h1 : 2'h0)
      && (!i_sck || (o_lvds_current == 3'h0 && !o_term_on))) else $error("output strap wrong");
   strap_pd_a: assert property (strap_s |-> o_sleep == (i_sdi && i_sdo)
      && o_ch1_nap == (i_sdi && !i_sdo) && (o_sleep || o_ch2_nap == (i_sdi ^ i_sdo)))
      else $error("power strap wrong");
   data_clock_a: assert property (take_s |=> o_output_data_clock != $past(o_output_data_clock))
      else $error("data clock missed a word");
   word_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid
      && $stable(o_ch1_sample_bits) && $stable(o_ch2_sample_bits)) else $error("word lost in stall");
   smp_answer_a: assert property (i_smp_valid && o_smp_ready && !o_out_valid |=> o_out_valid)
      else $error("no word after take");
endmodule
bind amf_top amf_props #(.SMP_W(SMP_W)) u_props (.*);

// File: test/amf_host.sv
// Host controller model driving the mode port pins.
// Assumes a pull-up on the shared data-out line; bench calls xfer.
`timescale 1ns/10ps
module amf_host (
   // Device side
   input wire logic i_sdo,
   input wire logic i_sdo_oe_b,
   output logic o_cs_b,
   output logic o_sck,
   output logic o_sdi,
   output logic o_sdo_pin,
   // Strap control
   input wire logic i_strap,
   input wire logic [3:0] i_straps
);
   logic cs_r = 1'b1;
   logic sck_r = 1'b0;
   logic sdi_r = 1'b0;
   assign o_cs_b = i_strap ? i_straps[3] : cs_r;
   assign o_sck = i_strap ? i_straps[2] : sck_r;
   assign o_sdi = i_strap ? i_straps[1] : sdi_r;
   // Pull-up wins unless the device pulls low
   assign o_sdo_pin = i_strap ? i_straps[0] : !(!i_sdo_oe_b && !i_sdo);
   // frame of n bits, first bit first, read bits sampled mid-high
   task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
      rd = 8'h00;
      cs_r = 1'b0;
      #100;
      for (int i = 0; i < n; i++) begin
         sdi_r = (i < 16) ? w[15-i] : ~sdi_r;
         #100 sck_r = 1'b1;
         #50 if (i >= 8 && i < 16) rd = {rd[6:0], o_sdo_pin};
         #50 sck_r = 1'b0;
      end
      #100 cs_r = 1'b1;
      #200;
   endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the converter mode-control block.
// Assumes amf_top, amf_host and the bound checker are compiled first.
`timescale 1ns/10ps
module testbench;
   logic i_sys_clk, i_rst_b, i_program_style_select, i_smp_valid, i_out_ready;
   logic i_ch1_over_range_flag, i_ch2_over_range_flag, i_cs_b, i_sck, i_sdi, i_sdo;
   logic [15:0] i_ch1_sample_bits, i_ch2_sample_bits, o_ch1_sample_bits, o_ch2_sample_bits;
   logic o_sdo, o_sdo_oe_b, o_smp_ready, o_out_valid, o_ch1_over_range_flag, o_ch2_over_range_flag;
   logic o_output_data_clock, o_out_oe_b, o_dcs_on, o_term_on, o_clk_invert;
   logic o_ch1_nap, o_ch2_nap, o_sleep, sleep_seen;
   logic [1:0] o_out_mode, o_clk_phase;
   logic [2:0] o_lvds_current;
   logic [3:0] straps;
   logic [31:0] seed;
   logic [33:0] expq[$];
   logic [5:0] dfs[10] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h07, 6'h1F, 6'h2C, 6'h27, 6'h0F, 6'h17};
   int failures, compares, cyc, ph;
   amf_top u_dut (.*);
   amf_host u_host (.i_sdo(o_sdo), .i_sdo_oe_b(o_sdo_oe_b), .o_cs_b(i_cs_b), .o_sck(i_sck),
      .o_sdi(i_sdi), .o_sdo_pin(i_sdo), .i_strap(i_program_style_select), .i_straps(straps));
   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cyc++;
      if (o_sleep === 1'b1) sleep_seen <= 1'b1;
      if (cyc == 40000) begin
         failures++;
         print_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [16:0] fmt(input logic [16:0] w, input logic [5:0] df, input int p);
      logic [15:0] d;
      d = w[15:0];
      case (df[5:3])
         amf_pkg::TP_ONES: return 17'h1FFFF;
         amf_pkg::TP_ZEROS: return 17'h00000;
         amf_pkg::TP_ALTERNATE: return p[0] ? 17'h00000 : 17'h1FFFF;
         amf_pkg::TP_CHECKER: return p[0] ? 17'h0AAAA : 17'h15555;
         default: ;
      endcase
      if (df[0]) d[15] = ~d[15];
      if (df[1]) d[15:1] = d[15:1] ^ {15{d[0]}};
      if (df[2]) d = d ^ 16'hAAAA;
      return {w[16], d};
   endfunction
   function automatic logic [2:0] pwr(input logic [1:0] c);
      return (c == 2'h3) ? 3'h4 : (c == 2'h2) ? 3'h3 : (c == 2'h1) ? 3'h1 : 3'h0;
   endfunction
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic push(input logic [5:0] df);
      logic [31:0] a, b;
      a = rnd();
      b = rnd();
      expq.push_back({fmt(a[16:0], df, ph), fmt(b[16:0], df, ph)});
      ph++;
      @(posedge i_sys_clk);
      #2 i_ch1_sample_bits = a[15:0];
      i_ch1_over_range_flag = a[16];
      i_ch2_sample_bits = b[15:0];
      i_ch2_over_range_flag = b[16];
      i_smp_valid = 1'b1;
      do @(negedge i_sys_clk); while (o_smp_ready !== 1'b1);
      @(posedge i_sys_clk);
      #2 i_smp_valid = 1'b0;
   endtask
   task automatic pop();
      logic [33:0] e;
      e = expq.pop_front();
      do @(negedge i_sys_clk); while (o_out_valid !== 1'b1);
      chk({o_ch1_over_range_flag, o_ch1_sample_bits, o_ch2_over_range_flag, o_ch2_sample_bits}, e);
      @(posedge i_sys_clk);
      #2;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] x;
      u_host.xfer({1'b0, a, d}, 16, x);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] x;
      logic [31:0] r;
      r = rnd();
      u_host.xfer({1'b1, a, r[7:0]}, 16, x);
      chk(x, e);
   endtask
   task automatic print_verdict();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      logic [7:0] d, x;
      logic [31:0] r;
      seed = 32'h07D4;
      {i_rst_b, i_program_style_select, i_smp_valid, i_out_ready, straps} = 8'h00;
      {i_ch1_sample_bits, i_ch2_sample_bits, i_ch1_over_range_flag, i_ch2_over_range_flag} = 34'h0;
      sleep_seen = 1'b0;
      repeat (16) @(posedge i_sys_clk);
      #2 i_rst_b = 1'b1;
      repeat (4) @(posedge i_sys_clk);
      #2;
      // software reset is the first command
      wr(amf_pkg::ADDR_RESET, 8'h80);
      chk(sleep_seen, 1'b1);
      rd_chk(amf_pkg::ADDR_RESET, 8'h00);
      rd_chk(amf_pkg::ADDR_DATA_FORMAT, 8'h00);
      $display("test soft reset done");
      for (int c = 3; c >= 0; c--) begin
         wr(amf_pkg::ADDR_POWER_DOWN, 8'(c));
         rd_chk(amf_pkg::ADDR_POWER_DOWN, 8'(c));
         chk({o_sleep, o_ch1_nap & (c != 3), o_ch2_nap & (c != 3)}, pwr(2'(c)));
      end
      // data trusted only after the nap recovery wait
      repeat (100) @(posedge i_sys_clk);
      #2;
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         wr(amf_pkg::ADDR_TIMING, r[7:0] & 8'h0F);
         wr(amf_pkg::ADDR_OUTPUT_MODE, r[15:8] & 8'h79);
         rd_chk(amf_pkg::ADDR_TIMING, r[7:0] & 8'h0F);
         rd_chk(amf_pkg::ADDR_OUTPUT_MODE, r[15:8] & 8'h79);
         rd_chk(amf_pkg::ADDR_OUTPUT_MODE, r[15:8] & 8'h79);
         chk({o_clk_invert, o_clk_phase, o_dcs_on}, r[3:0]);
         chk({o_lvds_current, o_term_on, o_out_mode, o_out_oe_b}, {r[14:11], 1'b0, r[8], 1'b0});
      end
      wr(amf_pkg::ADDR_TIMING, 8'h05);
      u_host.xfer({1'b0, amf_pkg::ADDR_TIMING, 8'h0A}, 12, x);
      rd_chk(amf_pkg::ADDR_TIMING, 8'h05);
      u_host.xfer({1'b0, amf_pkg::ADDR_TIMING, 8'h0A}, 20, x);
      rd_chk(amf_pkg::ADDR_TIMING, 8'h0A);
      $display("test serial port done");
      // sleep both channels before floating the outputs
      wr(amf_pkg::ADDR_POWER_DOWN, 8'h03);
      wr(amf_pkg::ADDR_OUTPUT_MODE, 8'h04);
      chk(o_out_oe_b, 1'b1);
      wr(amf_pkg::ADDR_OUTPUT_MODE, 8'h00);
      wr(amf_pkg::ADDR_POWER_DOWN, 8'h00);
      chk(o_out_oe_b, 1'b0);
      repeat (100) @(posedge i_sys_clk);
      #2;
      for (int k = 0; k < 10; k++) begin
         wr(amf_pkg::ADDR_DATA_FORMAT, {2'b00, dfs[k]});
         ph = 0;
         @(posedge i_sys_clk);
         #2 i_out_ready = 1'b0;
         push(dfs[k]);
         push(dfs[k]);
         @(negedge i_sys_clk);
         chk(o_smp_ready, 1'b0);
         @(posedge i_sys_clk);
         #2 i_out_ready = 1'b1;
         repeat (2) pop();
         repeat (2) begin
            push(dfs[k]);
            pop();
         end
      end
      $display("test formatting done");
      @(posedge i_sys_clk);
      #2 i_program_style_select = 1'b1;
      for (int v = 0; v < 16; v++) begin
         straps = 4'(v);
         repeat (8) @(posedge i_sys_clk);
         #2 chk(o_dcs_on, straps[3]);
         chk({o_out_mode, o_lvds_current, o_term_on}, {straps[2] ? 2'h1 : 2'h0, 4'h0});
         chk({o_sleep, o_ch1_nap & ~&straps[1:0], o_ch2_nap & ~&straps[1:0]}, pwr(straps[1:0]));
      end
      straps = 4'h8;
      ph = 0;
      push(6'h00);
      pop();
      $display("test strap mode done");
      print_verdict();
   end
endmodule
